// file: hw/status_sel_pkg.sv
// Package with the constants, types and register map of the output function selector.
package status_sel_pkg;

    localparam int CODE_W     = 6;
    localparam int DATA_W     = 16;
    localparam int ADDR_W     = 4;
    localparam int ANALOG_W   = 12;
    localparam int NUM_OUTS   = 3;

    typedef logic [CODE_W-1:0]   code_t;
    typedef logic [DATA_W-1:0]   data_t;
    typedef logic [ADDR_W-1:0]   addr_t;
    typedef logic [ANALOG_W-1:0] analog_t;
    typedef logic [63:0]         cond_t;

    // Selection codes.
    localparam code_t CODE_NONE          = 6'h00;
    localparam code_t CODE_IOL           = 6'h06;
    localparam code_t CODE_UNDERLOAD     = 6'h07;
    localparam code_t CODE_FAN_WARN      = 6'h08;
    localparam code_t CODE_STALL         = 6'h09;
    localparam code_t CODE_OVER_VOLT     = 6'h0a;
    localparam code_t CODE_LOW_VOLT      = 6'h0b;
    localparam code_t CODE_OVER_HEAT     = 6'h0c;
    localparam code_t CODE_LOST_CMD      = 6'h0d;
    localparam code_t CODE_RUN           = 6'h0e;
    localparam code_t CODE_STOP          = 6'h0f;
    localparam code_t CODE_STEADY        = 6'h10;
    localparam code_t CODE_DRIVE_LINE    = 6'h11;
    localparam code_t CODE_MAINS_LINE    = 6'h12;
    localparam code_t CODE_SPEED_SEARCH  = 6'h13;
    localparam code_t CODE_READY         = 6'h16;
    localparam code_t CODE_TIMER_OUT     = 6'h1c;
    localparam code_t CODE_TRIP          = 6'h1d;
    localparam code_t CODE_BRAKE_DUTY    = 6'h1f;
    localparam code_t CODE_ONOFF         = 6'h22;
    localparam code_t CODE_BRAKE_RELEASE = 6'h23;

    // Register indices on the plain register port.
    localparam addr_t REG_SEL_Q1     = 4'h0;
    localparam addr_t REG_SEL_RLY3   = 4'h1;
    localparam addr_t REG_SEL_RLY4   = 4'h2;
    localparam addr_t REG_TIMER_DLY  = 4'h3;
    localparam addr_t REG_ONOFF_HI   = 4'h4;
    localparam addr_t REG_ONOFF_LO   = 4'h5;
    localparam addr_t REG_OUT_STATE  = 4'h6;
    localparam addr_t REG_COND_LO    = 4'h7;
    localparam addr_t REG_COND_HI    = 4'h8;

    // Reset values.
    localparam code_t   RST_SEL_Q1    = CODE_NONE;
    localparam code_t   RST_SEL_RLY   = CODE_TRIP;
    localparam data_t   RST_TIMER_DLY = 16'h0000;
    localparam analog_t RST_ONOFF_HI  = 12'hfff;
    localparam analog_t RST_ONOFF_LO  = 12'h000;

    // Output state bit positions.
    localparam int OUT_Q1_BIT   = 0;
    localparam int OUT_RLY3_BIT = 1;
    localparam int OUT_RLY4_BIT = 2;

    // Timer tick of one millisecond at the 25 ns system clock.
    localparam int CLK_PERIOD_NS      = 25;
    localparam int TIMER_TICK_NS      = 1000000;
    localparam int TIMER_TICK_CYCLES  = (TIMER_TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic [1:0] {
        TMR_IDLE = 2'b00,
        TMR_RUN  = 2'b01,
        TMR_DONE = 2'b10
    } timer_e;

    // Status flags that the drive control logic feeds in.
    typedef struct packed {
        logic inverse_time_overload_trip;
        logic underload_warn;
        logic fan_warn;
        logic stall;
        logic dc_over_volt;
        logic dc_low_volt;
        logic overheat;
        logic analog_cmd_lost;
        logic rs485_cmd_lost;
        logic exp_card_fitted;
        logic exp_analog_lost;
        logic exp_comm_lost;
        logic run_cmd;
        logic output_voltage;
        logic dc_braking;
        logic steady;
        logic inverter_feed;
        logic mains_feed;
        logic speed_search;
        logic ready;
        logic fault_trip;
        logic brake_resistor_duty_alarm;
        logic brake_release_req;
        logic timer_trigger;
    } drive_status_s;

    typedef struct packed {
        logic                   wr;
        logic                   rd;
        addr_t                  addr;
        data_t                  wdata;
    } reg_req_s;

    function automatic data_t pad_code(input code_t c);
        pad_code = {{(DATA_W-CODE_W){1'b0}}, c};
    endfunction

    function automatic data_t pad_analog(input analog_t a);
        pad_analog = {{(DATA_W-ANALOG_W){1'b0}}, a};
    endfunction

endpackage

// file: hw/output_select.sv
// One selectable output: picks the condition named by its selection code and registers it.
`timescale 1ns/100ps
module output_select
    import status_sel_pkg::*;
(
    // Clock and reset
    input  wire logic  clk_sys,
    input  wire logic  rstn,
    // Selection
    input  wire code_t code,
    input  wire cond_t cond,
    // Output
    output logic       out_reg
);

    logic sel_bit;

    // Codes with no function index zero bits of the condition vector.
    assign sel_bit = cond[code];

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            out_reg <= 1'b0;
        end else begin
            out_reg <= sel_bit;
        end
    end

endmodule

// file: hw/status_output_selector.sv
// Output function selector for the terminal output and the two relay outputs.
`timescale 1ns/100ps
module status_output_selector
    import status_sel_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = TIMER_TICK_CYCLES
)
(
    // Clock and reset
    input  wire logic          clk_sys,
    input  wire logic          rstn,
    // Register port
    input  wire reg_req_s      reg_req,
    output data_t              rdata_reg,
    // Drive status
    input  wire drive_status_s status,
    input  wire analog_t       analog_value,
    // Outputs
    output logic               multi_function_output_terminal,
    output logic               relay3_out,
    output logic               relay4_out
);

    // Software registers.
    code_t   sel_q1_reg;
    code_t   sel_rly3_reg;
    code_t   sel_rly4_reg;
    data_t   timer_dly_reg;
    analog_t onoff_hi_reg;
    analog_t onoff_lo_reg;

    // Internal state.
    timer_e  tmr_state_reg;
    timer_e  tmr_state_next;
    logic [31:0] tick_cnt_reg;
    data_t   ms_cnt_reg;
    logic    tick;
    logic    onoff_reg;
    logic    onoff_next;
    logic    timer_out;
    cond_t   cond;
    code_t   sel_codes [NUM_OUTS];
    logic    outs [NUM_OUTS];
    logic [NUM_OUTS-1:0] output_state_parameter;
    data_t   rd_mux;

    // Register write decode.
    logic wr_q1;
    logic wr_rly3;
    logic wr_rly4;
    logic wr_tmr;
    logic wr_hi;
    logic wr_lo;

    assign wr_q1   = reg_req.wr && reg_req.addr == REG_SEL_Q1;
    assign wr_rly3 = reg_req.wr && reg_req.addr == REG_SEL_RLY3;
    assign wr_rly4 = reg_req.wr && reg_req.addr == REG_SEL_RLY4;
    assign wr_tmr  = reg_req.wr && reg_req.addr == REG_TIMER_DLY;
    assign wr_hi   = reg_req.wr && reg_req.addr == REG_ONOFF_HI;
    assign wr_lo   = reg_req.wr && reg_req.addr == REG_ONOFF_LO;

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            sel_q1_reg    <= RST_SEL_Q1;
            sel_rly3_reg  <= RST_SEL_RLY;
            sel_rly4_reg  <= RST_SEL_RLY;
            timer_dly_reg <= RST_TIMER_DLY;
            onoff_hi_reg  <= RST_ONOFF_HI;
            onoff_lo_reg  <= RST_ONOFF_LO;
        end else begin
            if (wr_q1) begin
                sel_q1_reg <= reg_req.wdata[CODE_W-1:0];
            end
            if (wr_rly3) begin
                sel_rly3_reg <= reg_req.wdata[CODE_W-1:0];
            end
            if (wr_rly4) begin
                sel_rly4_reg <= reg_req.wdata[CODE_W-1:0];
            end
            if (wr_tmr) begin
                timer_dly_reg <= reg_req.wdata;
            end
            if (wr_hi) begin
                onoff_hi_reg <= reg_req.wdata[ANALOG_W-1:0];
            end
            if (wr_lo) begin
                onoff_lo_reg <= reg_req.wdata[ANALOG_W-1:0];
            end
        end
    end

    // Millisecond tick for the timer output; it runs only while the timer counts.
    assign tick = tmr_state_reg == TMR_RUN && tick_cnt_reg == 32'(TICK_CYCLES - 1);

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            tick_cnt_reg <= 32'h0;
        end else if (tmr_state_reg != TMR_RUN || tick) begin
            tick_cnt_reg <= 32'h0;
        end else begin
            tick_cnt_reg <= tick_cnt_reg + 32'h1;
        end
    end

    // Timer output: counts while the trigger input is held, drops with the trigger.
    always_comb begin
        tmr_state_next = tmr_state_reg;
        unique case (tmr_state_reg)
            TMR_IDLE: begin
                if (status.timer_trigger) begin
                    tmr_state_next = (timer_dly_reg == 16'h0) ? TMR_DONE : TMR_RUN;
                end
            end
            TMR_RUN: begin
                if (!status.timer_trigger) begin
                    tmr_state_next = TMR_IDLE;
                end else if (tick && ms_cnt_reg == timer_dly_reg - 16'h1) begin
                    tmr_state_next = TMR_DONE;
                end
            end
            TMR_DONE: begin
                if (!status.timer_trigger) begin
                    tmr_state_next = TMR_IDLE;
                end
            end
            default: begin
                tmr_state_next = TMR_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            tmr_state_reg <= TMR_IDLE;
            ms_cnt_reg    <= 16'h0;
        end else begin
            tmr_state_reg <= tmr_state_next;
            if (tmr_state_reg != TMR_RUN) begin
                ms_cnt_reg <= 16'h0;
            end else if (tick) begin
                ms_cnt_reg <= ms_cnt_reg + 16'h1;
            end
        end
    end

    assign timer_out = tmr_state_reg == TMR_DONE;

    // Hysteresis between the two levels keeps the output from chattering on a noisy input.
    always_comb begin
        onoff_next = onoff_reg;
        if (analog_value >= onoff_hi_reg) begin
            onoff_next = 1'b1;
        end else if (analog_value <= onoff_lo_reg) begin
            onoff_next = 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            onoff_reg <= 1'b0;
        end else begin
            onoff_reg <= onoff_next;
        end
    end

    // Condition vector indexed by selection code; every other bit stays zero.
    always_comb begin
        cond                     = '0;
        cond[CODE_IOL]           = status.inverse_time_overload_trip;
        cond[CODE_UNDERLOAD]     = status.underload_warn;
        cond[CODE_FAN_WARN]      = status.fan_warn;
        cond[CODE_STALL]         = status.stall;
        cond[CODE_OVER_VOLT]     = status.dc_over_volt;
        cond[CODE_LOW_VOLT]      = status.dc_low_volt;
        cond[CODE_OVER_HEAT]     = status.overheat;
        cond[CODE_LOST_CMD]      = status.analog_cmd_lost || status.rs485_cmd_lost
                                   || (status.exp_card_fitted
                                       && (status.exp_analog_lost || status.exp_comm_lost));
        cond[CODE_RUN]           = status.run_cmd && status.output_voltage && !status.dc_braking;
        cond[CODE_STOP]          = !status.run_cmd && !status.output_voltage;
        cond[CODE_STEADY]        = status.steady;
        cond[CODE_DRIVE_LINE]    = status.inverter_feed;
        cond[CODE_MAINS_LINE]    = status.mains_feed;
        cond[CODE_SPEED_SEARCH]  = status.speed_search;
        cond[CODE_READY]         = status.ready;
        cond[CODE_TIMER_OUT]     = timer_out;
        cond[CODE_TRIP]          = status.fault_trip;
        cond[CODE_BRAKE_DUTY]    = status.brake_resistor_duty_alarm;
        cond[CODE_ONOFF]         = onoff_reg;
        cond[CODE_BRAKE_RELEASE] = status.brake_release_req;
    end

    assign sel_codes[OUT_Q1_BIT]   = sel_q1_reg;
    assign sel_codes[OUT_RLY3_BIT] = sel_rly3_reg;
    assign sel_codes[OUT_RLY4_BIT] = sel_rly4_reg;

    // Each output has its own selector and selection code, so the relays can be set independently.
    for (genvar i = 0; i < NUM_OUTS; i++) begin : g_out
        output_select u_sel (
            .clk_sys (clk_sys),
            .rstn    (rstn),
            .code    (sel_codes[i]),
            .cond    (cond),
            .out_reg (outs[i])
        );
        assign output_state_parameter[i] = outs[i];
    end

    assign multi_function_output_terminal = outs[OUT_Q1_BIT];
    assign relay3_out                     = outs[OUT_RLY3_BIT];
    assign relay4_out                     = outs[OUT_RLY4_BIT];

    // Register read multiplexer; unmapped addresses read as zero.
    always_comb begin
        rd_mux = 16'h0;
        unique case (reg_req.addr)
            REG_SEL_Q1:    rd_mux = pad_code(sel_q1_reg);
            REG_SEL_RLY3:  rd_mux = pad_code(sel_rly3_reg);
            REG_SEL_RLY4:  rd_mux = pad_code(sel_rly4_reg);
            REG_TIMER_DLY: rd_mux = timer_dly_reg;
            REG_ONOFF_HI:  rd_mux = pad_analog(onoff_hi_reg);
            REG_ONOFF_LO:  rd_mux = pad_analog(onoff_lo_reg);
            REG_OUT_STATE: rd_mux = {13'h0, output_state_parameter};
            REG_COND_LO:   rd_mux = cond[15:0];
            REG_COND_HI:   rd_mux = cond[31:16];
            default:       rd_mux = 16'h0;
        endcase
    end

    // Read data stand only in the cycle after the read strobe.
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            rdata_reg <= 16'h0;
        end else begin
            rdata_reg <= reg_req.rd ? rd_mux : 16'h0;
        end
    end

endmodule

// file: test/relay_load_model.sv
// Behavioural relay coil and terminal load driven by the selector outputs.
`timescale 1ns/100ps
module relay_load_model (
    // Clock and reset
    input  wire logic       clk_sys,
    input  wire logic       rstn,
    // Coil drive and contact state
    input  wire logic [2:0] coil_drive,
    output logic      [2:0] contact_closed
);
    // The contact follows its coil one clock later; no bounce is modelled.
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            contact_closed <= 3'h0;
        end else begin
            contact_closed <= coil_drive;
        end
    end
endmodule

// file: test/status_output_selector_sva.sv
// Port checker for the output function selector, bound to its top module.
`timescale 1ns/100ps
module status_output_selector_sva
    import status_sel_pkg::*;
(
    // Clock and reset
    input wire logic          clk_sys,
    input wire logic          rstn,
    // Register port
    input wire reg_req_s      reg_req,
    input wire data_t         rdata_reg,
    // Drive side
    input wire drive_status_s status,
    input wire analog_t       analog_value,
    input wire logic          multi_function_output_terminal,
    input wire logic          relay3_out,
    input wire logic          relay4_out
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    code_t q1_sel_reg;
    code_t r3_sel_reg;
    code_t r4_sel_reg;
    wire   code_t new_code = reg_req.wdata[CODE_W-1:0];
    wire   code_t q1_sel_next = (reg_req.wr && reg_req.addr == REG_SEL_Q1) ? new_code : q1_sel_reg;
    wire   code_t r3_sel_next = (reg_req.wr && reg_req.addr == REG_SEL_RLY3) ? new_code : r3_sel_reg;
    wire   code_t r4_sel_next = (reg_req.wr && reg_req.addr == REG_SEL_RLY4) ? new_code : r4_sel_reg;
    // Shadows of the selection codes, so that no internal signal has to be reached.
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            q1_sel_reg <= RST_SEL_Q1;
            r3_sel_reg <= RST_SEL_RLY;
            r4_sel_reg <= RST_SEL_RLY;
        end else begin
            q1_sel_reg <= q1_sel_next;
            r3_sel_reg <= r3_sel_next;
            r4_sel_reg <= r4_sel_next;
        end
    end
    // A settled code is required, since a code change may cost the design one more cycle.
    a_iol_trip: assert property ($stable(q1_sel_reg) && q1_sel_reg == CODE_IOL
        && status.inverse_time_overload_trip |=> multi_function_output_terminal) else $error("overload trip not shown");
    a_lost_cmd: assert property ($stable(q1_sel_reg) && q1_sel_reg == CODE_LOST_CMD |=>
        multi_function_output_terminal == $past(status.analog_cmd_lost | status.rs485_cmd_lost
        | (status.exp_card_fitted & (status.exp_analog_lost | status.exp_comm_lost))))
        else $error("lost command output wrong");
    a_run_gate: assert property ($stable(q1_sel_reg) && q1_sel_reg == CODE_RUN |=>
        multi_function_output_terminal == $past(status.run_cmd & status.output_voltage & ~status.dc_braking))
        else $error("run output wrong");
    a_stop_state: assert property ($stable(q1_sel_reg) && q1_sel_reg == CODE_STOP |=>
        multi_function_output_terminal == $past(~status.run_cmd & ~status.output_voltage))
        else $error("stop output wrong");
    a_trip_relay: assert property ($stable(r3_sel_reg) && r3_sel_reg == CODE_TRIP |=>
        relay3_out == $past(status.fault_trip)) else $error("trip relay wrong");
    a_duty_relay: assert property ($stable(r3_sel_reg) && r3_sel_reg == CODE_BRAKE_DUTY |=>
        relay3_out == $past(status.brake_resistor_duty_alarm)) else $error("duty relay wrong");
    a_mains_relay: assert property ($stable(r4_sel_reg) && r4_sel_reg == CODE_MAINS_LINE |=>
        relay4_out == $past(status.mains_feed)) else $error("mains relay wrong");
    a_brake_rel: assert property ($stable(q1_sel_reg) && q1_sel_reg == CODE_BRAKE_RELEASE |=>
        multi_function_output_terminal == $past(status.brake_release_req)) else $error("brake release wrong");
    a_unused_off: assert property ($stable(q1_sel_reg) && q1_sel_reg inside {[0:5], 20, 21, [23:27], 30,
        32, 33, [36:63]} |=> !multi_function_output_terminal) else $error("unassigned code drives output");
endmodule
bind status_output_selector status_output_selector_sva chk_u (.clk_sys(clk_sys), .rstn(rstn), .reg_req(reg_req),
    .rdata_reg(rdata_reg), .status(status), .analog_value(analog_value),
    .multi_function_output_terminal(multi_function_output_terminal), .relay3_out(relay3_out),
    .relay4_out(relay4_out));

// file: test/tb_top.sv
// Self-checking bench for the output function selector.
`timescale 1ns/100ps
module tb_top;
    import status_sel_pkg::*;
    logic          clk_sys = 1'b0;
    logic          rstn = 1'b0;
    reg_req_s      reg_req = '0;
    data_t         rdata_reg;
    drive_status_s st = '0;
    analog_t       ana = '0;
    logic          q1_out;
    logic          r3_out;
    logic          r4_out;
    logic    [2:0] contacts;
    logic          rd_d = 1'b0;
    int            fails = 0;
    int            n_tests = 0;
    int            look_n = 0;
    int            seen_n = 0;
    data_t         exp_q[$];
    data_t         e_out;
    analog_t       levels[8] = '{12'h900, 12'h600, 12'h300, 12'h600, 12'h800, 12'h7ff, 12'h400, 12'h401};
    logic          onoff_exp[8] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
    always #12.5 clk_sys = ~clk_sys;
    status_output_selector #(.TICK_CYCLES(4)) dut_u (.clk_sys(clk_sys), .rstn(rstn), .reg_req(reg_req),
        .rdata_reg(rdata_reg), .status(st), .analog_value(ana), .multi_function_output_terminal(q1_out),
        .relay3_out(r3_out), .relay4_out(r4_out));
    relay_load_model load_u (.clk_sys(clk_sys), .rstn(rstn), .coil_drive({r4_out, r3_out, q1_out}),
        .contact_closed(contacts));
    function automatic logic cond_of(input code_t c, input drive_status_s s);
        case (c)
            CODE_IOL:           cond_of = s.inverse_time_overload_trip;
            CODE_UNDERLOAD:     cond_of = s.underload_warn;
            CODE_FAN_WARN:      cond_of = s.fan_warn;
            CODE_STALL:         cond_of = s.stall;
            CODE_OVER_VOLT:     cond_of = s.dc_over_volt;
            CODE_LOW_VOLT:      cond_of = s.dc_low_volt;
            CODE_OVER_HEAT:     cond_of = s.overheat;
            CODE_LOST_CMD:      cond_of = s.analog_cmd_lost | s.rs485_cmd_lost
                                    | (s.exp_card_fitted & (s.exp_analog_lost | s.exp_comm_lost));
            CODE_RUN:           cond_of = s.run_cmd & s.output_voltage & ~s.dc_braking;
            CODE_STOP:          cond_of = ~s.run_cmd & ~s.output_voltage;
            CODE_STEADY:        cond_of = s.steady;
            CODE_DRIVE_LINE:    cond_of = s.inverter_feed;
            CODE_MAINS_LINE:    cond_of = s.mains_feed;
            CODE_SPEED_SEARCH:  cond_of = s.speed_search;
            CODE_READY:         cond_of = s.ready;
            CODE_TRIP:          cond_of = s.fault_trip;
            CODE_BRAKE_DUTY:    cond_of = s.brake_resistor_duty_alarm;
            CODE_BRAKE_RELEASE: cond_of = s.brake_release_req;
            default:            cond_of = 1'b0;
        endcase
    endfunction
    // Sixteen condition bits starting at a code, as the condition read-back registers show them.
    function automatic data_t cond_word(input int base, input drive_status_s s);
        for (int j = 0; j < 16; j++) begin
            cond_word[j] = cond_of(code_t'(base + j), s);
        end
    endfunction
    task automatic chk(input string what, input data_t e, input data_t s);
        n_tests++;
        if (s !== e) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, s);
        end
    endtask
    task automatic wr(input addr_t a, input data_t d);
        @(posedge clk_sys);
        reg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    endtask
    task automatic rd(input addr_t a, input data_t e);
        @(posedge clk_sys);
        reg_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: '0};
        exp_q.push_back(e);
    endtask
    task automatic idle(input int n);
        @(posedge clk_sys);
        reg_req <= '0;
        repeat (n) @(posedge clk_sys);
    endtask
    task automatic look(input logic [2:0] e);
        @(posedge clk_sys);
        exp_q.push_back({13'h0, e});
        look_n <= look_n + 1;
    endtask
    task automatic final_report();
        $display("Comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // Results are taken on the falling edge, half a cycle after they settle.
    always @(posedge clk_sys) rd_d <= reg_req.rd;
    always @(negedge clk_sys) begin
        if (rd_d) begin
            chk("rdata_reg", exp_q.pop_front(), rdata_reg);
        end
        if (look_n != seen_n) begin
            seen_n = look_n;
            e_out = exp_q.pop_front();
            chk("outputs", e_out, {13'h0, r4_out, r3_out, q1_out});
            chk("contacts", e_out, {13'h0, contacts});
        end
    end
    initial begin
        code_t         c;
        drive_status_s s;
        logic [31:0]   r;
        logic [2:0]    e;
        void'($urandom(73754));
        repeat (5) @(posedge clk_sys);
        rstn <= 1'b1;
        rd(REG_SEL_Q1, {10'h0, RST_SEL_Q1});
        rd(REG_SEL_RLY3, {10'h0, RST_SEL_RLY});
        rd(REG_SEL_RLY4, {10'h0, RST_SEL_RLY});
        rd(REG_TIMER_DLY, RST_TIMER_DLY);
        rd(REG_ONOFF_HI, {4'h0, RST_ONOFF_HI});
        rd(REG_ONOFF_LO, {4'h0, RST_ONOFF_LO});
        rd(4'h9, 16'h0000);
        wr(REG_OUT_STATE, 16'h0007);
        wr(4'hc, 16'hffff);
        wr(REG_SEL_Q1, 16'hffea);
        rd(REG_SEL_Q1, 16'h002a);
        rd(REG_OUT_STATE, 16'h0000);
        rd(4'hc, 16'h0000);
        wr(REG_SEL_Q1, {10'h0, CODE_TIMER_OUT});
        wr(REG_TIMER_DLY, 16'h0003);
        idle(3);
        st.timer_trigger <= 1'b1;
        repeat (9) @(posedge clk_sys);
        look(3'h0);
        repeat (6) @(posedge clk_sys);
        look(3'h1);
        st.timer_trigger <= 1'b0;
        repeat (3) @(posedge clk_sys);
        look(3'h0);
        wr(REG_ONOFF_HI, 16'h0800);
        wr(REG_ONOFF_LO, 16'h0400);
        wr(REG_SEL_Q1, {10'h0, CODE_ONOFF});
        idle(2);
        foreach (levels[k]) begin
            ana <= levels[k];
            repeat (4) @(posedge clk_sys);
            look({2'b00, onoff_exp[k]});
        end
        ana <= '0;
        // Two passes give every code two random status words; trigger and analog stay low to keep history out.
        for (int i = 0; i < 128; i++) begin
            c = code_t'(i);
            r = $urandom();
            s = drive_status_s'(r[23:0]);
            s.timer_trigger = 1'b0;
            e = {cond_of(c ^ 6'h2a, s), cond_of(~c, s), cond_of(c, s)};
            wr(REG_SEL_Q1, {10'h0, c});
            wr(REG_SEL_RLY3, {10'h0, ~c});
            wr(REG_SEL_RLY4, {10'h0, c ^ 6'h2a});
            st <= s;
            idle(3);
            look(e);
            rd(REG_OUT_STATE, {13'h0, e});
            rd(REG_COND_LO, cond_word(0, s));
            rd(REG_COND_HI, cond_word(16, s));
            idle(0);
        end
        idle(2);
        // A reset in mid-run must bring back the settings and drop every output.
        st <= '0;
        rstn <= 1'b0;
        idle(2);
        rstn <= 1'b1;
        rd(REG_SEL_Q1, {10'h0, RST_SEL_Q1});
        rd(REG_SEL_RLY4, {10'h0, RST_SEL_RLY});
        rd(REG_ONOFF_HI, {4'h0, RST_ONOFF_HI});
        rd(REG_OUT_STATE, 16'h0000);
        idle(2);
        final_report();
    end
    initial begin
        repeat (5000) @(posedge clk_sys);
        fails++;
        final_report();
    end
endmodule
